//--- include/setup_pkg.sv
/*
 * Constants, types and carriers of the controller setup memory.
 * Assumes a single 200 MHz clock domain and word-indexed register addresses.
 */
package setup_pkg;

	// ==========================================================
	// Setup area placement
	localparam logic [15:0] SETUP_FIRST_ADDR        = 16'h19c8;
	localparam logic [15:0] SETUP_LAST_ADDR         = 16'h19ff;
	localparam logic [15:0] STARTUP_MODE_WORD       = 16'h19c8;
	localparam logic [15:0] HOLD_BIT_RETENTION_WORD = 16'h19c9;
	localparam int          SETUP_WORDS             = 56;

	typedef logic [5:0] sidx_t;

	localparam sidx_t IDX_STARTUP     = 6'h00;
	localparam sidx_t IDX_HOLD        = 6'h01;
	localparam sidx_t IDX_PWR_LAST    = 6'h0e;
	localparam sidx_t IDX_START_FIRST = 6'h0f;
	localparam sidx_t IDX_START_LAST  = 6'h2c;
	localparam sidx_t IDX_CONT_FIRST  = 6'h2d;
	localparam sidx_t IDX_CONT_LAST   = 6'h37;
	localparam sidx_t IDX_TWICE_PWR   = 6'h2b;
	localparam sidx_t IDX_TWICE_START = 6'h0b;

	// ==========================================================
	// Word values and fields
	localparam logic [15:0] SETUP_DEFAULT   = 16'h0000;
	localparam logic [7:0]  SEL_CONSOLE     = 8'h00;
	localparam logic [7:0]  SEL_LAST        = 8'h01;
	localparam logic [7:0]  SEL_EXPLICIT    = 8'h02;
	localparam logic [7:0]  MODE_CODE_MAX   = 8'h02;
	localparam int          HOLD_IOM_LSB    = 8;
	localparam int          HOLD_FORCED_LSB = 12;
	localparam logic [3:0]  HOLD_RETAIN     = 4'h1;
	localparam logic [7:0]  SETUP_VALUE_ERROR_CODE = 8'h9b;

	typedef enum logic [1:0] {
		MODE_PROGRAM = 2'b00,
		MODE_MONITOR = 2'b01,
		MODE_RUN     = 2'b10
	} op_mode_t;

	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_SCAN  = 2'b01,
		SEQ_CLEAR = 2'b10
	} seq_t;

	// Scan groups, also the error flag positions
	localparam logic [1:0] GRP_PWR   = 2'h0;
	localparam logic [1:0] GRP_START = 2'h1;
	localparam logic [1:0] GRP_CONT  = 2'h2;

	// ==========================================================
	// Own registers
	localparam logic [15:0] CTRL_ADDR       = 16'h1a00;
	localparam logic [15:0] STATUS_ADDR     = 16'h1a01;
	localparam logic [15:0] IRQ_EN_ADDR     = 16'h1a02;
	localparam logic [15:0] IRQ_CLR_ADDR    = 16'h1a03;
	localparam logic [15:0] ERR_FLAGS_ADDR  = 16'h1a04;
	localparam logic [15:0] STATE_VIEW_ADDR = 16'h1a05;

	localparam int ST_LOAD_DONE    = 0;
	localparam int ST_SETUP_ERR    = 1;
	localparam int ST_WR_REFUSED   = 2;
	localparam int ST_RESTORE_DONE = 3;

	localparam logic [3:0] RST_STATUS    = 4'h0;
	localparam logic [3:0] RST_IRQ_EN    = 4'h0;
	localparam logic [2:0] RST_ERR_FLAGS = 3'h0;
	localparam logic [7:0] RST_ERR_CODE  = 8'h00;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        clearDm;
		logic        modeSet;
		op_mode_t    modeVal;
	} prog_req_t;

	typedef struct packed {
		logic        stb;
		sidx_t       idx;
		logic [15:0] data;
	} applied_t;

endpackage

//--- verilog/setup_word_mem.sv
/*
 * Setup word storage: one write port, one read port with registered data.
 * The read register can instead load a word supplied by the caller.
 */
module setup_word_mem (
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	input  wire logic                  wrEn,
	input  wire setup_pkg::sidx_t      wrIdx,
	input  wire logic [15:0]           wrData,
	input  wire logic                  rdEn,
	input  wire setup_pkg::sidx_t      rdIdx,
	input  wire logic                  rdAlt,
	input  wire logic [15:0]           rdAltData,
	output logic      [15:0]           rdData
);

	// ==========================================================
	// Storage
	logic [15:0] words [setup_pkg::SETUP_WORDS];

	always_ff @(posedge mclk) begin
		if (wrEn) begin
			words[wrIdx] <= wrData;
		end
	end

	// ==========================================================
	// Read register
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rdData <= 16'h0000;
		end else if (rdEn) begin
			rdData <= rdAlt ? rdAltData : words[rdIdx];
		end
	end

endmodule

//--- verilog/controller_setup_memory.sv
/*
 * Controller setup memory: stores the setup words, loads them at power-up,
 * program start or continuously, checks and decodes them, guards writes.
 * Assumes the user program on the register port and a programming device
 * on the programming port, both synchronous to mclk.
 */
// The implementer's own choice: the strobed register port.
// What this block does
// - Setup words occupy word addresses 6600 through 6655 contiguously.
// - Every setup word defaults to 0000, selecting default behaviour.
// - Setting the restore bit returns all setup words to default, any time.
// - A data-memory clear from the programming device zeroes every setup word.
// - Words 6600-6614 are read and applied at power-up, 6611 also at program start.
// - Words 6615-6644 are read and applied at program start, 6643 also at power-up.
// - Words 6645-6655 are applied continuously while powered.
// - Words 6611 and 6643 are sampled at power-up and at program start.
// - Only the programming device writes setup words; user writes are refused.
// - Words 6600-6644 are writable only in program mode.
// - Words 6645-6655 are writable in program or monitor mode.
// - An improper word raises non-fatal error code 9B, operation continues.
// - An improper word sets its error flag and is applied as default.
// - Startup word low byte picks console, last mode, or explicit mode.
// - With low byte 02, the high byte gives program, monitor or run.
// - At power-up, retain bits keep old value if field is 1, else clear.
module controller_setup_memory (
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	input  wire setup_pkg::reg_req_t   regReq,
	output logic      [15:0]           regRdData,
	input  wire setup_pkg::prog_req_t  progReq,
	input  wire logic                  powerUp,
	input  wire logic                  progStart,
	input  wire logic                  consoleAttached,
	input  wire setup_pkg::op_mode_t   consoleMode,
	input  wire setup_pkg::op_mode_t   lastMode,
	input  wire logic                  prevForcedRetain,
	input  wire logic                  prevIoRetain,
	output setup_pkg::op_mode_t        opMode,
	output logic                       forcedStateRetainBit,
	output logic                       ioMemoryRetainBit,
	output logic      [2:0]            setupErrorFlags,
	output logic      [7:0]            setupErrCode,
	output setup_pkg::applied_t        applied,
	output logic                       irq
);

	// ==========================================================
	// State
	typedef struct packed {
		setup_pkg::seq_t     seq;
		setup_pkg::sidx_t    idx;
		setup_pkg::sidx_t    last;
		logic                extra;
		setup_pkg::sidx_t    extraIdx;
		logic [1:0]          grp;
		logic                pend;
		setup_pkg::sidx_t    pendIdx;
		logic [1:0]          pendGrp;
		logic                pwrPend;
		logic                startPend;
		logic                clearPend;
		logic                restore;
		logic [3:0]          status;
		logic [3:0]          irqEn;
		logic [2:0]          errFlags;
		logic [7:0]          errCode;
		setup_pkg::op_mode_t mode;
		logic                forced;
		logic                io;
		setup_pkg::applied_t applied;
		logic                irq;
	} state_t;

	state_t r;
	state_t s;

	logic                memWrEn;
	setup_pkg::sidx_t    memWrIdx;
	logic [15:0]         memWrData;
	logic                memRdEn;
	setup_pkg::sidx_t    memRdIdx;
	logic                memRdAlt;
	logic [15:0]         memRdAltData;
	logic [15:0]         memRdData;

	// ==========================================================
	// Helpers
	function automatic logic improper(input setup_pkg::sidx_t idx, input logic [15:0] w);
		logic bad;
		bad = 1'b0;
		if (idx == setup_pkg::IDX_STARTUP) begin
			bad = (w[7:0] > setup_pkg::SEL_EXPLICIT) ||
			      ((w[7:0] == setup_pkg::SEL_EXPLICIT) && (w[15:8] > setup_pkg::MODE_CODE_MAX));
		end else if (idx == setup_pkg::IDX_HOLD) begin
			bad = (w[7:0] != 8'h00) ||
			      (w[setup_pkg::HOLD_IOM_LSB +: 4] > setup_pkg::HOLD_RETAIN) ||
			      (w[setup_pkg::HOLD_FORCED_LSB +: 4] > setup_pkg::HOLD_RETAIN);
		end
		return bad;
	endfunction

	function automatic setup_pkg::op_mode_t codeToMode(input logic [7:0] c);
		setup_pkg::op_mode_t m;
		case (c)
			8'h00: m = setup_pkg::MODE_PROGRAM;
			8'h01: m = setup_pkg::MODE_MONITOR;
			default: m = setup_pkg::MODE_RUN;
		endcase
		return m;
	endfunction

	// ==========================================================
	// Next state
	logic [15:0]         busOff;
	logic                busSetup;
	logic [15:0]         progOff;
	logic                progSetup;
	logic                progAllowed;
	logic [15:0]         word;
	logic [3:0]          stSet;
	logic [3:0]          stClr;
	logic [2:0]          efSet;
	logic [2:0]          efClr;

	always_comb begin
		s = r;
		s.applied.stb = 1'b0;
		stSet = 4'h0;
		stClr = 4'h0;
		efSet = 3'h0;
		efClr = 3'h0;
		word = 16'h0000;
		memWrEn = 1'b0;
		memWrIdx = r.idx;
		memWrData = setup_pkg::SETUP_DEFAULT;
		memRdEn = 1'b0;
		memRdIdx = r.idx;
		memRdAlt = 1'b0;
		memRdAltData = 16'h0000;

		busOff = regReq.addr - setup_pkg::SETUP_FIRST_ADDR;
		busSetup = (regReq.addr >= setup_pkg::SETUP_FIRST_ADDR) &&
		           (regReq.addr <= setup_pkg::SETUP_LAST_ADDR);
		progOff = progReq.addr - setup_pkg::SETUP_FIRST_ADDR;
		progSetup = (progReq.addr >= setup_pkg::SETUP_FIRST_ADDR) &&
		            (progReq.addr <= setup_pkg::SETUP_LAST_ADDR);

		// User program reads: setup words or own registers
		if (regReq.rd) begin
			memRdEn = 1'b1;
			memRdIdx = busOff[5:0];
			if (!busSetup) begin
				memRdAlt = 1'b1;
				case (regReq.addr)
					setup_pkg::CTRL_ADDR:       memRdAltData = {15'h0000, r.restore};
					setup_pkg::STATUS_ADDR:     memRdAltData = {12'h000, r.status};
					setup_pkg::IRQ_EN_ADDR:     memRdAltData = {12'h000, r.irqEn};
					setup_pkg::ERR_FLAGS_ADDR:  memRdAltData = {13'h0000, r.errFlags};
					setup_pkg::STATE_VIEW_ADDR: memRdAltData = {r.errCode, 2'h0, r.io,
					                                            r.forced, 2'h0, r.mode};
					default:                    memRdAltData = 16'h0000;
				endcase
			end
		end

		// Apply a word read by the sequencer
		if (r.pend) begin
			s.pend = 1'b0;
			word = memRdData;
			if (improper(r.pendIdx, memRdData)) begin
				word = setup_pkg::SETUP_DEFAULT;
				efSet[r.pendGrp] = 1'b1;
				s.errCode = setup_pkg::SETUP_VALUE_ERROR_CODE;
				stSet[setup_pkg::ST_SETUP_ERR] = 1'b1;
			end
			s.applied.stb = 1'b1;
			s.applied.idx = r.pendIdx;
			s.applied.data = word;
			if (r.pendGrp == setup_pkg::GRP_PWR) begin
				if (r.pendIdx == setup_pkg::IDX_STARTUP) begin
					case (word[7:0])
						setup_pkg::SEL_LAST:     s.mode = lastMode;
						setup_pkg::SEL_EXPLICIT: s.mode = codeToMode(word[15:8]);
						default:                 s.mode = consoleAttached ? consoleMode :
						                                  setup_pkg::MODE_RUN;
					endcase
				end else if (r.pendIdx == setup_pkg::IDX_HOLD) begin
					s.forced = (word[setup_pkg::HOLD_FORCED_LSB +: 4] == setup_pkg::HOLD_RETAIN) ?
					           prevForcedRetain : 1'b0;
					s.io = (word[setup_pkg::HOLD_IOM_LSB +: 4] == setup_pkg::HOLD_RETAIN) ?
					       prevIoRetain : 1'b0;
				end
			end
		end

		// Sequencer
		case (r.seq)
			setup_pkg::SEQ_IDLE: begin
				if (r.restore || r.clearPend) begin
					s.seq = setup_pkg::SEQ_CLEAR;
					s.idx = 6'h00;
					s.clearPend = 1'b0;
				end else if (r.pwrPend) begin
					s.seq = setup_pkg::SEQ_SCAN;
					s.idx = setup_pkg::IDX_STARTUP;
					s.last = setup_pkg::IDX_PWR_LAST;
					s.extra = 1'b1;
					s.extraIdx = setup_pkg::IDX_TWICE_PWR;
					s.grp = setup_pkg::GRP_PWR;
					s.pwrPend = 1'b0;
				end else if (r.startPend) begin
					s.seq = setup_pkg::SEQ_SCAN;
					s.idx = setup_pkg::IDX_START_FIRST;
					s.last = setup_pkg::IDX_START_LAST;
					s.extra = 1'b1;
					s.extraIdx = setup_pkg::IDX_TWICE_START;
					s.grp = setup_pkg::GRP_START;
					s.startPend = 1'b0;
				end else begin
					s.seq = setup_pkg::SEQ_SCAN;
					s.idx = setup_pkg::IDX_CONT_FIRST;
					s.last = setup_pkg::IDX_CONT_LAST;
					s.extra = 1'b0;
					s.grp = setup_pkg::GRP_CONT;
				end
			end
			setup_pkg::SEQ_SCAN: begin
				if (!regReq.rd) begin
					memRdEn = 1'b1;
					memRdIdx = r.idx;
					s.pend = 1'b1;
					s.pendIdx = r.idx;
					s.pendGrp = r.grp;
					if (r.idx == r.last) begin
						if (r.extra) begin
							s.idx = r.extraIdx;
							s.last = r.extraIdx;
							s.extra = 1'b0;
						end else begin
							s.seq = setup_pkg::SEQ_IDLE;
							if (r.grp != setup_pkg::GRP_CONT) begin
								stSet[setup_pkg::ST_LOAD_DONE] = 1'b1;
							end
						end
					end else begin
						s.idx = r.idx + 6'h01;
					end
				end
			end
			setup_pkg::SEQ_CLEAR: begin
				memWrEn = 1'b1;
				memWrIdx = r.idx;
				memWrData = setup_pkg::SETUP_DEFAULT;
				if (r.idx == setup_pkg::IDX_CONT_LAST) begin
					s.seq = setup_pkg::SEQ_IDLE;
					if (r.restore) begin
						s.restore = 1'b0;
						stSet[setup_pkg::ST_RESTORE_DONE] = 1'b1;
					end
				end else begin
					s.idx = r.idx + 6'h01;
				end
			end
			default: begin
				s.seq = setup_pkg::SEQ_IDLE;
			end
		endcase

		// User program writes
		if (regReq.wr) begin
			case (regReq.addr)
				setup_pkg::CTRL_ADDR: begin
					if (regReq.wdata[0]) begin
						s.restore = 1'b1;
					end
				end
				setup_pkg::IRQ_EN_ADDR:    s.irqEn = regReq.wdata[3:0];
				setup_pkg::IRQ_CLR_ADDR:   stClr = regReq.wdata[3:0];
				setup_pkg::ERR_FLAGS_ADDR: efClr = regReq.wdata[2:0];
				default: begin
					if (busSetup) begin
						stSet[setup_pkg::ST_WR_REFUSED] = 1'b1;
					end
				end
			endcase
		end

		// Programming device writes, gated by mode
		if (progOff[5:0] <= setup_pkg::IDX_START_LAST) begin
			progAllowed = (r.mode == setup_pkg::MODE_PROGRAM);
		end else begin
			progAllowed = (r.mode == setup_pkg::MODE_PROGRAM) ||
			              (r.mode == setup_pkg::MODE_MONITOR);
		end
		progAllowed = progAllowed && (r.seq != setup_pkg::SEQ_CLEAR);
		if (progReq.wr && progSetup) begin
			if (progAllowed) begin
				memWrEn = 1'b1;
				memWrIdx = progOff[5:0];
				memWrData = progReq.wdata;
			end else begin
				stSet[setup_pkg::ST_WR_REFUSED] = 1'b1;
			end
		end
		if (progReq.modeSet && (progReq.modeVal != 2'b11)) begin
			s.mode = progReq.modeVal;
		end

		// Load and clear events
		if (progReq.clearDm) begin
			s.clearPend = 1'b1;
		end
		if (powerUp) begin
			s.pwrPend = 1'b1;
		end
		if (progStart) begin
			s.startPend = 1'b1;
		end

		// Sticky flags: set wins over clear
		s.status = (r.status & ~stClr) | stSet;
		s.errFlags = (r.errFlags & ~efClr) | efSet;
		s.irq = |(s.status & s.irqEn);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			r.seq <= setup_pkg::SEQ_CLEAR;
			r.idx <= 6'h00;
			r.last <= 6'h00;
			r.extra <= 1'b0;
			r.extraIdx <= 6'h00;
			r.grp <= setup_pkg::GRP_PWR;
			r.pend <= 1'b0;
			r.pendIdx <= 6'h00;
			r.pendGrp <= setup_pkg::GRP_PWR;
			r.pwrPend <= 1'b0;
			r.startPend <= 1'b0;
			r.clearPend <= 1'b0;
			r.restore <= 1'b0;
			r.status <= setup_pkg::RST_STATUS;
			r.irqEn <= setup_pkg::RST_IRQ_EN;
			r.errFlags <= setup_pkg::RST_ERR_FLAGS;
			r.errCode <= setup_pkg::RST_ERR_CODE;
			r.mode <= setup_pkg::MODE_PROGRAM;
			r.forced <= 1'b0;
			r.io <= 1'b0;
			r.applied <= '0;
			r.irq <= 1'b0;
		end else begin
			r <= s;
		end
	end

	// ==========================================================
	// Storage
	setup_word_mem u_mem (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.wrEn      (memWrEn),
		.wrIdx     (memWrIdx),
		.wrData    (memWrData),
		.rdEn      (memRdEn),
		.rdIdx     (memRdIdx),
		.rdAlt     (memRdAlt),
		.rdAltData (memRdAltData),
		.rdData    (memRdData)
	);

	// ==========================================================
	// Outputs
	assign regRdData            = memRdData;
	assign opMode               = r.mode;
	assign forcedStateRetainBit = r.forced;
	assign ioMemoryRetainBit    = r.io;
	assign setupErrorFlags      = r.errFlags;
	assign setupErrCode         = r.errCode;
	assign applied              = r.applied;
	assign irq                  = r.irq;

endmodule

//--- testbench/setup_prog_device.sv
/*
 * Programming device model: writes setup words, sets the mode, clears memory.
 * Assumes it shares mclk with the setup memory and acts after rising edges.
 */
module setup_prog_device (
	input  wire logic            mclk,
	output setup_pkg::prog_req_t progReq
);
	timeunit 1ns;
	timeprecision 1ps;

	initial progReq = '0;

	// ==========================================================
	// Requests
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		progReq.wr <= 1'b1;
		progReq.addr <= a;
		progReq.wdata <= d;
		@(posedge mclk);
		progReq.wr <= 1'b0;
		progReq.addr <= ~a;
		progReq.wdata <= ~d;
	endtask

	task automatic mode(input setup_pkg::op_mode_t m);
		@(posedge mclk);
		progReq.modeSet <= 1'b1;
		progReq.modeVal <= m;
		@(posedge mclk);
		progReq.modeSet <= 1'b0;
	endtask

	task automatic clr();
		@(posedge mclk);
		progReq.clearDm <= 1'b1;
		@(posedge mclk);
		progReq.clearDm <= 1'b0;
	endtask
endmodule

//--- testbench/setup_mem_sva.sv
/*
 * Port checker of the setup memory.
 * Assumes binding to controller_setup_memory, one clock domain.
 */
module setup_mem_sva (
	input wire logic                mclk,
	input wire logic                sys_rst,
	input wire setup_pkg::reg_req_t regReq,
	input wire logic                consoleAttached,
	input wire setup_pkg::op_mode_t consoleMode,
	input wire setup_pkg::op_mode_t lastMode,
	input wire logic                prevForcedRetain,
	input wire logic                prevIoRetain,
	input wire setup_pkg::op_mode_t opMode,
	input wire logic                forcedStateRetainBit,
	input wire logic                ioMemoryRetainBit,
	input wire logic [2:0]          setupErrorFlags,
	input wire logic [7:0]          setupErrCode,
	input wire setup_pkg::applied_t applied,
	input wire logic                irq
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	function automatic setup_pkg::op_mode_t modeOf(input logic [15:0] w);
		if (w[7:0] == 8'h00)
			return consoleAttached ? consoleMode : setup_pkg::MODE_RUN;
		if (w[7:0] == 8'h01)
			return lastMode;
		return setup_pkg::op_mode_t'(w[9:8]);
	endfunction

	// ==========================================================
	// Scan order
	sequence pwrTail;
		applied.stb && applied.idx == setup_pkg::IDX_PWR_LAST;
	endsequence
	sequence startTail;
		applied.stb && applied.idx == setup_pkg::IDX_START_LAST;
	endsequence
	sequence contTail;
		applied.stb && applied.idx == setup_pkg::IDX_CONT_LAST;
	endsequence

	property startP;
		logic [15:0] w;
		(applied.stb && applied.idx == setup_pkg::IDX_STARTUP, w = applied.data)
			|=> opMode == modeOf(w);
	endproperty
	property holdP;
		logic [15:0] w;
		(applied.stb && applied.idx == setup_pkg::IDX_HOLD, w = applied.data)
			|=> forcedStateRetainBit == (w[15:12] == 4'h1 && prevForcedRetain)
			&& ioMemoryRetainBit == (w[11:8] == 4'h1 && prevIoRetain);
	endproperty

	// ==========================================================
	// Assertions
	idx_range_a: assert property (applied.stb |-> applied.idx <= 6'h37)
		else $error("applied index outside setup area");
	err_code_a: assert property (setupErrCode == 8'h00 || setupErrCode == 8'h9b)
		else $error("error code has a foreign value");
	flag_code_a: assert property ($rose(|setupErrorFlags) |-> ##[0:1] setupErrCode == 8'h9b)
		else $error("error flag without error code");
	flag_sticky_a: assert property (!$past(regReq.wr) |->
		(setupErrorFlags & $past(setupErrorFlags)) == $past(setupErrorFlags))
		else $error("error flag dropped by itself");
	start_mode_a: assert property (startP)
		else $error("startup mode wrong");
	mode_proper_a: assert property (applied.stb && applied.idx == 6'h00 |->
		applied.data[7:0] <= 8'h02 && (applied.data[7:0] != 8'h02 || applied.data[15:8] <= 8'h02))
		else $error("improper startup word applied");
	hold_retain_a: assert property (holdP)
		else $error("retain bits wrong");
	pwr_twice_a: assert property (pwrTail |-> ##[1:3] applied.stb && applied.idx == 6'h2b)
		else $error("second word missing after power-up scan");
	start_twice_a: assert property (startTail |-> ##[1:3] applied.stb && applied.idx == 6'h0b)
		else $error("second word missing after start scan");
	cont_loop_a: assert property (contTail |-> ##[1:200] applied.stb && applied.idx == 6'h2d)
		else $error("continuous scan stopped");
	irq_fall_a: assert property ($fell(irq) |-> $past(regReq.wr))
		else $error("interrupt dropped without a write");
endmodule

bind controller_setup_memory setup_mem_sva u_sva (.mclk, .sys_rst, .regReq, .consoleAttached,
	.consoleMode, .lastMode, .prevForcedRetain, .prevIoRetain, .opMode, .forcedStateRetainBit,
	.ioMemoryRetainBit, .setupErrorFlags, .setupErrCode, .applied, .irq);

//--- testbench/test_controller_setup_memory.sv
/*
 * Self-checking bench of the setup memory.
 * Assumes setup_pkg, the programming device model and the checker.
 */
module test_controller_setup_memory;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [15:0] word;
		logic        ca;
		logic [1:0]  mode;
		logic        bad;
	} case_t;
	localparam case_t TBL [8] = '{'{16'h0000, 1'b1, 2'h1, 1'b0}, '{16'h0000, 1'b0, 2'h2, 1'b0},
		'{16'h0001, 1'b1, 2'h2, 1'b0}, '{16'h0002, 1'b1, 2'h0, 1'b0},
		'{16'h0102, 1'b1, 2'h1, 1'b0}, '{16'h0202, 1'b1, 2'h2, 1'b0},
		'{16'h0302, 1'b1, 2'h1, 1'b1}, '{16'h0003, 1'b1, 2'h1, 1'b1}};

	logic                mclk = 1'b0;
	logic                sys_rst = 1'b1;
	setup_pkg::reg_req_t regReq = '0;
	logic [15:0]         regRdData;
	setup_pkg::prog_req_t progReq;
	logic                powerUp = 1'b0;
	logic                progStart = 1'b0;
	logic                consoleAttached = 1'b0;
	logic                prevForcedRetain = 1'b0;
	logic                prevIoRetain = 1'b0;
	setup_pkg::op_mode_t opMode;
	logic                forcedStateRetainBit;
	logic                ioMemoryRetainBit;
	logic [2:0]          setupErrorFlags;
	logic [7:0]          setupErrCode;
	setup_pkg::applied_t applied;
	logic                irq;
	logic [15:0]         expQ [$];
	logic                rdSeen = 1'b0;
	logic                f, io, pf, pi, seenBad;
	logic [15:0]         hv;
	int                  badCount = 0;
	int                  totalChecks = 0;
	int                  cyc = 0;

	always #2.5 mclk = ~mclk;

	controller_setup_memory u_dut (.mclk(mclk), .sys_rst(sys_rst), .regReq(regReq),
		.regRdData(regRdData), .progReq(progReq), .powerUp(powerUp), .progStart(progStart),
		.consoleAttached(consoleAttached), .consoleMode(setup_pkg::MODE_MONITOR),
		.lastMode(setup_pkg::MODE_RUN), .prevForcedRetain(prevForcedRetain),
		.prevIoRetain(prevIoRetain), .opMode(opMode), .forcedStateRetainBit(forcedStateRetainBit),
		.ioMemoryRetainBit(ioMemoryRetainBit), .setupErrorFlags(setupErrorFlags),
		.setupErrCode(setupErrCode), .applied(applied), .irq(irq));
	setup_prog_device u_prog (.mclk(mclk), .progReq(progReq));

	// ==========================================================
	// Checking and closing
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		totalChecks++;
		if (got !== exp) begin
			badCount++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic endSim();
		if (badCount == 0 && totalChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge mclk) begin
		if (rdSeen)
			cmp(regRdData, expQ.pop_front());
		rdSeen <= regReq.rd;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			badCount++;
			endSim();
		end
	end

	// ==========================================================
	// Drivers
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		regReq <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge mclk);
		regReq.wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge mclk);
		regReq <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
		expQ.push_back(e);
		@(posedge mclk);
		regReq.rd <= 1'b0;
	endtask

	task automatic ev(input logic pwr);
		@(posedge mclk);
		powerUp <= pwr;
		progStart <= !pwr;
		@(posedge mclk);
		powerUp <= 1'b0;
		progStart <= 1'b0;
	endtask

	task automatic waitIdx(input setup_pkg::sidx_t i);
		int n = 0;
		while (!(applied.stb === 1'b1 && applied.idx === i) && n < 400) begin
			@(posedge mclk);
			n++;
		end
		cmp(16'(n == 400), 16'h0000);
		repeat (2) @(posedge mclk);
	endtask

	// ==========================================================
	// Scenarios
	initial begin
		void'($urandom(32'h9575557d));
		seenBad = 1'b0;
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (60) @(posedge mclk);
		rd(setup_pkg::STARTUP_MODE_WORD, 16'h0000);
		wr(setup_pkg::STARTUP_MODE_WORD, 16'h0102);
		rd(setup_pkg::STARTUP_MODE_WORD, 16'h0000);
		rd(setup_pkg::STATUS_ADDR, 16'h0004);
		rd(16'h1a06, 16'h0000);
		wr(setup_pkg::IRQ_EN_ADDR, 16'h0004);
		@(posedge mclk);
		cmp(16'(irq), 16'h0001);
		wr(setup_pkg::IRQ_CLR_ADDR, 16'h0004);
		wr(setup_pkg::IRQ_EN_ADDR, 16'h0000);
		wr(setup_pkg::HOLD_BIT_RETENTION_WORD, 16'h1100);
		@(posedge mclk);
		cmp(16'(irq), 16'h0000);
		rd(setup_pkg::IRQ_CLR_ADDR, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			f = 1'($urandom);
			io = 1'($urandom);
			pf = 1'($urandom);
			pi = 1'($urandom);
			hv = {3'h0, f, 3'h0, io, 8'h00};
			consoleAttached <= TBL[i].ca;
			prevForcedRetain <= pf;
			prevIoRetain <= pi;
			u_prog.mode(setup_pkg::MODE_PROGRAM);
			u_prog.wr(setup_pkg::STARTUP_MODE_WORD, TBL[i].word);
			u_prog.wr(setup_pkg::HOLD_BIT_RETENTION_WORD, hv);
			@(posedge mclk);
			cmp(16'(opMode), 16'h0000);
			ev(1'b1);
			waitIdx(setup_pkg::IDX_TWICE_PWR);
			cmp(16'(opMode), 16'(TBL[i].mode));
			cmp(16'(forcedStateRetainBit), 16'(f & pf));
			cmp(16'(ioMemoryRetainBit), 16'(io & pi));
			cmp(16'(setupErrorFlags), 16'(TBL[i].bad));
			seenBad = seenBad | TBL[i].bad;
			cmp(16'(setupErrCode), seenBad ? 16'h009b : 16'h0000);
			rd(setup_pkg::ERR_FLAGS_ADDR, 16'(TBL[i].bad));
			wr(setup_pkg::ERR_FLAGS_ADDR, 16'h0007);
		end
		u_prog.mode(setup_pkg::MODE_MONITOR);
		u_prog.wr(16'h19f5, 16'h00a5);
		rd(16'h19f5, 16'h00a5);
		u_prog.wr(setup_pkg::HOLD_BIT_RETENTION_WORD, ~hv);
		rd(setup_pkg::HOLD_BIT_RETENTION_WORD, hv);
		u_prog.mode(setup_pkg::MODE_RUN);
		u_prog.wr(16'h19f5, 16'h5a5a);
		rd(16'h19f5, 16'h00a5);
		u_prog.wr(16'h19d7, 16'h0001);
		rd(16'h19d7, 16'h0000);
		ev(1'b0);
		waitIdx(setup_pkg::IDX_TWICE_START);
		u_prog.clr();
		repeat (70) @(posedge mclk);
		rd(16'h19f5, 16'h0000);
		u_prog.mode(setup_pkg::MODE_PROGRAM);
		u_prog.wr(16'h19f5, 16'h0077);
		rd(16'h19f5, 16'h0077);
		wr(setup_pkg::CTRL_ADDR, 16'h0001);
		rd(setup_pkg::CTRL_ADDR, 16'h0001);
		repeat (80) @(posedge mclk);
		rd(setup_pkg::CTRL_ADDR, 16'h0000);
		rd(16'h19f5, 16'h0000);
		rd(setup_pkg::STATUS_ADDR, 16'h000f);
		rd(setup_pkg::STATE_VIEW_ADDR, {setup_pkg::SETUP_VALUE_ERROR_CODE, 2'h0, io & pi, f & pf, 4'h0});
		repeat (3) @(posedge mclk);
		endSim();
	end
endmodule
